// ### hdl/llrc_pkg.sv
package llrc_pkg;
  localparam int CLK_KHZ = 100000;
  localparam int PWR_WAIT_MS = 10;
  localparam int TRAIN_MS = 21;
  localparam int HRST_HOLD_US = 1000;
  localparam int CONFIRM_US = 2;
  localparam int PWR_WAIT_CYC = PWR_WAIT_MS * CLK_KHZ;
  localparam int TRAIN_CYC = TRAIN_MS * CLK_KHZ;
  localparam int HRST_HOLD_CYC = HRST_HOLD_US * CLK_KHZ / 1000;
  localparam int CONFIRM_CYC = CONFIRM_US * CLK_KHZ / 1000;
  localparam logic [4:0] DRV_FAIL_SPAN = 5'h0F;
  localparam logic [4:0] NO_SIG_SPAN = 5'h1F;
  localparam int ES_DEPTH = 8;
  localparam int SCLK_HALF = 16;
  // shared pin positions: hardware name / host name
  localparam int P_CABLE_SPAN_SEL_B0 = 0;
  localparam int P_INT = 0;
  localparam int P_CABLE_SPAN_SEL_B1 = 1;
  localparam int P_SDI = 1;
  localparam int P_CABLE_SPAN_SEL_B2 = 2;
  localparam int P_SDO = 2;
  localparam int P_RL = 3;
  localparam int P_CS = 3;
  localparam int P_LL = 4;
  localparam int P_SCLK = 4;
  localparam int P_AO = 5;
  localparam int P_ESEL = 5;
  // serial command and data byte
  localparam logic [5:0] DEV_ADDR = 6'h10;
  localparam int CMD_RW_BIT = 0;
  localparam int D_LOS = 0;
  localparam int D_DFAIL = 1;
  localparam int D_LEN = 2;
  localparam int D_RL = 5;
  localparam int D_LL = 6;
  localparam int D_AO = 7;
  localparam logic [7:0] DATA_RST = 8'h00;
  // controller registers
  localparam logic [3:0] H_CTRL_OFS = 4'h0;
  localparam logic [3:0] H_CMD_OFS = 4'h4;
  localparam logic [3:0] H_STAT_OFS = 4'h8;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_ESEL = 1;
  localparam int CMD_RD_BIT = 8;
  localparam int CMD_HRST_BIT = 9;
endpackage : llrc_pkg

// ### hdl/llrc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface llrc_if;
  logic mode;
  logic [5:0] host_out;
  logic [5:0] host_oe;
  logic [5:0] dev_out;
  logic [5:0] dev_oe;
  logic [5:0] pins;
  logic driver_fail_flag;
  logic no_signal_flag;
  // undriven pins pull high
  assign pins = (dev_oe & dev_out) | (~dev_oe & host_oe & host_out) | (~dev_oe & ~host_oe);
  modport dev (
    input mode,
    input pins,
    output dev_out,
    output dev_oe,
    output driver_fail_flag,
    output no_signal_flag
  );
  modport host (
    output mode,
    output host_out,
    output host_oe,
    input pins,
    input driver_fail_flag,
    input no_signal_flag
  );
endinterface : llrc_if
`default_nettype wire

// ### hdl/llrc_elastic_store.sv
`timescale 1ns/1ns
`default_nettype none
module llrc_elastic_store #(
  parameter int WIDTH = 2,
  parameter int DEPTH = llrc_pkg::ES_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  import llrc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic primed_q;

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_q[wp_q] <= wdata;
    end
  end

  // reads start half full; the slack absorbs jitter on either the write or the read side
  always_ff @(posedge mclk) begin
    if (rst || flush) begin
      wp_q <= '0;
      rp_q <= '0;
      primed_q <= 1'b0;
      rdata <= '0;
    end else begin
      if (wr_en) begin
        wp_q <= wp_q + AW'(1);
      end
      if (wr_en && wp_q == AW'(DEPTH / 2 - 1)) begin
        primed_q <= 1'b1;
      end
      if (rd_en && primed_q) begin
        rp_q <= rp_q + AW'(1);
        rdata <= mem_q[rp_q];
      end
    end
  end
endmodule : llrc_elastic_store
`default_nettype wire

// ### hdl/llrc_device.sv
// Overview of operation
// R01: local loop routes transmit side to receive outputs
// R02: local loop still transmits unless all-ones
// R03: all-ones sends AMI marks on alternate clock
// R04: remote loop retransmits recovered signal via store
// R05: remote loop keeps receive outputs live
// R06: source priority: remote, all-ones, normal
// R07: remote loop forwards bipolar violations unchanged
// R08: both loops together means reset request
// R09: driver-fail flag rests low, high on failure
// R10: no monitor pulse 15 to 31 cycles
// R11: controller reconfirms driver-fail before acting
// R12: host mode shows driver-fail in register too
// R13: power-up wait then loop training
// R14: controller requests reset after power settles
// R15: hardware reset pulse under 2 ms
// R16: host reset clears register then trains
// R17: no-signal flag high throughout reset
// R18: mode pin selects shared pin function
// R19: one serial register, own serial clock
// R20: chip select low starts, high ends transfer
// R21: serial inputs captured on serial clock rise
// R22: edge select sets output data edges
// R23: LSB-first command, address 16, read bit
// R24: data byte layout, status bits read-only
`timescale 1ns/1ns
`default_nettype none
module llrc_device #(
  parameter int PWR_WAIT = llrc_pkg::PWR_WAIT_CYC,
  parameter int TRAIN = llrc_pkg::TRAIN_CYC,
  parameter int ES_DEPTH = llrc_pkg::ES_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  llrc_if.dev lnk,
  input wire logic tx_clock,
  input wire logic tx_pos_data,
  input wire logic tx_neg_data,
  input wire logic alt_clock,
  input wire logic rec_clock,
  input wire logic rx_line_a,
  input wire logic rx_line_b,
  input wire logic mon_line_a,
  input wire logic mon_line_b,
  output logic tx_line_a,
  output logic tx_line_b,
  output logic tx_line_clk,
  output logic rx_pos_data,
  output logic rx_neg_data,
  output logic rx_clock_out,
  output logic [2:0] cable_span_sel,
  output logic freq_phase_loop_busy
);
  import llrc_pkg::*;

  typedef enum logic [3:0] {
    S_PWR = 4'h1,
    S_REQ = 4'h2,
    S_TRAIN = 4'h4,
    S_RUN = 4'h8
  } llrc_rst_type;

  localparam int I_TCK = 0;
  localparam int I_TP = 1;
  localparam int I_TN = 2;
  localparam int I_ACK = 3;
  localparam int I_RCK = 4;
  localparam int I_RA = 5;
  localparam int I_RB = 6;
  localparam int I_MA = 7;
  localparam int I_MB = 8;
  localparam int I_MODE = 9;
  localparam int I_PIN = 10;

  ////////////////////////////////////////////////////////////////////////////
  // every outside level passes two flops; edges come from the second
  logic [15:0] raw;
  logic [15:0] s1_q;
  logic [15:0] s2_q;
  logic [15:0] prev_q;
  logic [15:0] rise;
  logic [15:0] fall;
  assign raw = {lnk.pins, lnk.mode, mon_line_b, mon_line_a, rx_line_b, rx_line_a,
                rec_clock, alt_clock, tx_neg_data, tx_pos_data, tx_clock};

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      prev_q <= 16'h0000;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end
  assign rise = s2_q & ~prev_q;
  assign fall = ~s2_q & prev_q;

  logic host;
  logic [5:0] pin;
  assign host = s2_q[I_MODE];
  assign pin = s2_q[I_PIN+5:I_PIN];

  ////////////////////////////////////////////////////////////////////////////
  // control selection
  llrc_rst_type st_q;
  logic [31:0] cnt_q;
  logic [7:0] data_q;
  logic wr_q;
  logic host_rst;
  logic busy;
  logic rl_req;
  logic ll_req;
  logic ao_req;
  logic rl_on;
  logic ll_on;
  assign busy = (st_q != S_RUN);
  assign rl_req = host ? data_q[D_RL] : pin[P_RL]; // R18
  assign ll_req = host ? data_q[D_LL] : pin[P_LL]; // R18
  assign ao_req = host ? data_q[D_AO] : pin[P_AO]; // R18
  // the pair is never a loopback; it only ever means reset
  assign rl_on = rl_req & ~ll_req & ~busy; // R08
  assign ll_on = ll_req & ~rl_req & ~busy; // R08

  always_ff @(posedge mclk) begin
    if (rst) begin
      cable_span_sel <= 3'h0;
    end else begin
      cable_span_sel <= host ? data_q[D_LEN+2:D_LEN] : pin[P_CABLE_SPAN_SEL_B2:P_CABLE_SPAN_SEL_B0]; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset and loop training sequence
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= S_PWR;
      cnt_q <= 32'h0000_0000;
    end else begin
      unique case (st_q)
        S_PWR: begin
          if (cnt_q == 32'(PWR_WAIT - 1)) begin // R13
            st_q <= S_TRAIN;
            cnt_q <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        S_REQ: begin
          if (!(pin[P_RL] && pin[P_LL])) begin // R15
            st_q <= S_TRAIN;
          end
        end
        S_TRAIN: begin
          if (cnt_q == 32'(TRAIN - 1)) begin // R13
            st_q <= S_RUN;
            cnt_q <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        S_RUN: begin
          if (!host && pin[P_RL] && pin[P_LL]) begin // R08
            st_q <= S_REQ;
          end else if (host_rst) begin // R16
            st_q <= S_TRAIN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      freq_phase_loop_busy <= 1'b0;
    end else begin
      freq_phase_loop_busy <= (st_q == S_TRAIN); // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial port, host mode only
  logic [4:0] bit_q;
  logic [7:0] cmd_q;
  logic [7:0] wd_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic hit;
  logic launch;
  logic [7:0] rd_byte;
  assign hit = (cmd_q[6:1] == DEV_ADDR); // R23
  assign launch = pin[P_ESEL] ? fall[I_PIN+P_SCLK] : rise[I_PIN+P_SCLK]; // R22
  assign host_rst = wr_q & wd_q[D_RL] & wd_q[D_LL]; // R16
  assign rd_byte = {data_q[D_AO:D_LEN], lnk.driver_fail_flag, lnk.no_signal_flag}; // R12

  always_ff @(posedge mclk) begin
    if (rst) begin
      bit_q <= 5'h00;
      cmd_q <= 8'h00;
      wd_q <= 8'h00;
      wr_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (!host || pin[P_CS]) begin
        bit_q <= 5'h00; // R20
      end else if (rise[I_PIN+P_SCLK] && bit_q < 5'h10) begin // R21
        bit_q <= bit_q + 5'h01;
        if (bit_q < 5'h08) begin
          cmd_q[bit_q[2:0]] <= pin[P_SDI]; // R23
        end else begin
          wd_q[bit_q[2:0]] <= pin[P_SDI]; // R24
        end
        wr_q <= (bit_q == 5'h0F) && !cmd_q[CMD_RW_BIT] && hit; // R19
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      data_q <= DATA_RST;
    end else if (host_rst) begin
      data_q <= DATA_RST; // R16
    end else if (wr_q) begin
      data_q[D_AO:D_LEN] <= wd_q[D_AO:D_LEN]; // R24
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (!host || pin[P_CS]) begin
      sdo_oe_q <= 1'b0;
    end else if (launch && bit_q[4:3] == 2'h1 && cmd_q[CMD_RW_BIT] && hit) begin // R22
      sdo_q <= rd_byte[bit_q[2:0]];
      sdo_oe_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lnk.dev_out <= 6'h00;
      lnk.dev_oe <= 6'h00;
    end else begin
      lnk.dev_out <= 6'h00;
      lnk.dev_oe <= 6'h00;
      // alarm line is active low while either status is raised
      lnk.dev_out[P_INT] <= ~(lnk.no_signal_flag | lnk.driver_fail_flag);
      lnk.dev_out[P_SDO] <= sdo_q;
      lnk.dev_oe[P_INT] <= host; // R18
      lnk.dev_oe[P_SDO] <= host & sdo_oe_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line data paths
  logic ca_q;
  logic cb_q;
  logic ra_q;
  logic rb_q;
  logic pol_q;
  logic [1:0] es_data;
  logic inv;
  assign inv = host & pin[P_ESEL]; // R22

  always_ff @(posedge mclk) begin
    if (rst) begin
      ca_q <= 1'b0;
      cb_q <= 1'b0;
      ra_q <= 1'b0;
      rb_q <= 1'b0;
      pol_q <= 1'b0;
    end else begin
      if (rise[I_TCK]) begin
        ca_q <= s2_q[I_TP];
        cb_q <= s2_q[I_TN];
      end
      if (rise[I_RCK]) begin
        ra_q <= s2_q[I_RA];
        rb_q <= s2_q[I_RB];
      end
      if (rise[I_ACK]) begin
        pol_q <= ~pol_q; // R03
      end
    end
  end

  llrc_elastic_store #(
    .WIDTH(2),
    .DEPTH(ES_DEPTH)
  ) u_store (
    .mclk(mclk),
    .rst(rst),
    .flush(~rl_on),
    .wr_en(rise[I_RCK]),
    .rd_en(rise[I_RCK]),
    .wdata({s2_q[I_RA], s2_q[I_RB]}), // R07
    .rdata(es_data)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_line_a <= 1'b0;
      tx_line_b <= 1'b0;
      tx_line_clk <= 1'b0;
    end else if (rl_on) begin // R06
      tx_line_clk <= s2_q[I_RCK]; // R04
      tx_line_a <= s2_q[I_RCK] & es_data[1]; // R07
      tx_line_b <= s2_q[I_RCK] & es_data[0];
    end else if (ao_req) begin // R06
      tx_line_clk <= s2_q[I_ACK]; // R03
      tx_line_a <= s2_q[I_ACK] & pol_q;
      tx_line_b <= s2_q[I_ACK] & ~pol_q;
    end else begin
      tx_line_clk <= s2_q[I_TCK]; // R02
      tx_line_a <= s2_q[I_TCK] & ca_q;
      tx_line_b <= s2_q[I_TCK] & cb_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_pos_data <= 1'b0;
      rx_neg_data <= 1'b0;
      rx_clock_out <= 1'b0;
    end else if (ll_on) begin
      rx_pos_data <= ca_q; // R01
      rx_neg_data <= cb_q;
      rx_clock_out <= s2_q[I_TCK] ^ inv;
    end else begin
      rx_pos_data <= ra_q; // R05
      rx_neg_data <= rb_q;
      rx_clock_out <= s2_q[I_RCK] ^ inv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // driver monitor and signal loss
  logic [4:0] dcnt_q;
  logic [4:0] ncnt_q;
  logic sel_rise;
  assign sel_rise = rl_on ? rise[I_RCK] : (ao_req ? rise[I_ACK] : rise[I_TCK]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      dcnt_q <= 5'h00;
      lnk.driver_fail_flag <= 1'b0; // R09
    end else if (s2_q[I_MA] || s2_q[I_MB]) begin
      dcnt_q <= 5'h00;
      lnk.driver_fail_flag <= 1'b0; // R09
    end else if (sel_rise) begin
      if (dcnt_q == DRV_FAIL_SPAN) begin
        lnk.driver_fail_flag <= 1'b1; // R10
      end else begin
        dcnt_q <= dcnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ncnt_q <= 5'h00;
      lnk.no_signal_flag <= 1'b1;
    end else begin
      if (s2_q[I_RA] || s2_q[I_RB]) begin
        ncnt_q <= 5'h00;
      end else if (rise[I_RCK] && ncnt_q != NO_SIG_SPAN) begin
        ncnt_q <= ncnt_q + 5'h01;
      end
      lnk.no_signal_flag <= busy || (ncnt_q == NO_SIG_SPAN); // R17
    end
  end
endmodule : llrc_device
`default_nettype wire

// ### hdl/llrc_host.sv
`timescale 1ns/1ns
`default_nettype none
module llrc_host #(
  parameter int HRST_HOLD = llrc_pkg::HRST_HOLD_CYC,
  parameter int HALF = llrc_pkg::SCLK_HALF
) (
  input wire logic mclk,
  input wire logic rst,
  llrc_if.host lnk,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  import llrc_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_LOW = 5'h02,
    H_HIGH = 5'h04,
    H_DONE = 5'h08,
    H_HRST = 5'h10
  } llrc_host_type;

  llrc_host_type st_q;
  logic [7:0] ctrl_q;
  logic [15:0] sh_q;
  logic [7:0] rx_q;
  logic [3:0] hb_q;
  logic [31:0] tm_q;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [15:0] conf_q;
  logic conf_ok_q;
  logic sclk_q;
  logic cs_n_q;
  logic esel;
  logic half_end;
  assign esel = ctrl_q[CTRL_ESEL];
  assign half_end = (tm_q == 32'(HALF - 1));

  ////////////////////////////////////////////////////////////////////////////
  // device outputs are foreign: two flops first
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {lnk.driver_fail_flag, lnk.no_signal_flag, lnk.pins[P_SDO]};
      s2_q <= s1_q;
    end
  end

  // a short high at low ones density is not trusted
  always_ff @(posedge mclk) begin
    if (rst || !s2_q[2]) begin
      conf_q <= 16'h0000;
      conf_ok_q <= 1'b0;
    end else if (conf_q == 16'(CONFIRM_CYC)) begin
      conf_ok_q <= 1'b1; // R11
    end else begin
      conf_q <= conf_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial master and reset pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= H_IDLE;
      tm_q <= 32'h0000_0000;
      sh_q <= 16'h0000;
      rx_q <= 8'h00;
      hb_q <= 4'h0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      tm_q <= tm_q + 32'h0000_0001;
      unique case (st_q)
        H_IDLE: begin
          tm_q <= 32'h0000_0000;
          if (reg_wr && reg_addr == H_CMD_OFS) begin
            if (!ctrl_q[CTRL_MODE]) begin
              if (reg_wdata[CMD_HRST_BIT]) begin
                st_q <= H_HRST; // R14
              end
            end else begin
              sh_q <= {reg_wdata[7:0], 1'b0, DEV_ADDR, reg_wdata[CMD_RD_BIT]}; // R23
              hb_q <= 4'h0;
              cs_n_q <= 1'b0; // R20
              st_q <= H_LOW;
            end
          end
        end
        H_LOW: begin
          if (half_end) begin
            if (esel && hb_q[3]) begin
              rx_q[hb_q[2:0]] <= s2_q[0]; // R22
            end
            sclk_q <= 1'b1; // R21
            tm_q <= 32'h0000_0000;
            st_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_end) begin
            if (!esel && hb_q[3]) begin
              rx_q[hb_q[2:0]] <= s2_q[0]; // R22
            end
            sclk_q <= 1'b0;
            tm_q <= 32'h0000_0000;
            sh_q <= sh_q >> 1;
            hb_q <= hb_q + 4'h1;
            st_q <= (hb_q == 4'hF) ? H_DONE : H_LOW;
          end
        end
        H_DONE: begin
          if (half_end) begin
            cs_n_q <= 1'b1; // R20
            st_q <= H_IDLE;
          end
        end
        H_HRST: begin
          if (tm_q == 32'(HRST_HOLD - 1)) begin // R15
            st_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lnk.mode <= 1'b0;
      lnk.host_out <= 6'h00;
      lnk.host_oe <= 6'h00;
    end else begin
      lnk.mode <= ctrl_q[CTRL_MODE];
      if (!ctrl_q[CTRL_MODE]) begin
        lnk.host_out <= ctrl_q[D_AO:D_LEN];
        if (st_q == H_HRST) begin
          lnk.host_out[P_RL] <= 1'b1; // R08
          lnk.host_out[P_LL] <= 1'b1;
        end
        lnk.host_oe <= 6'h3F; // R18
      end else begin
        lnk.host_out <= 6'h00;
        lnk.host_out[P_SDI] <= sh_q[0];
        lnk.host_out[P_CS] <= cs_n_q;
        lnk.host_out[P_SCLK] <= sclk_q;
        lnk.host_out[P_ESEL] <= esel;
        lnk.host_oe <= 6'h3A; // R18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= 8'h00;
    end else if (reg_wr && reg_addr == H_CTRL_OFS) begin
      ctrl_q <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && reg_addr == H_CTRL_OFS) begin
      reg_rdata <= {8'h00, ctrl_q};
    end else if (reg_rd && reg_addr == H_STAT_OFS) begin
      reg_rdata <= {rx_q, 4'h0, conf_ok_q, s2_q[2], s2_q[1], st_q != H_IDLE};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : llrc_host
`default_nettype wire

// ### tb/llrc_sva.sv
`timescale 1ns/1ns
`default_nettype none
module llrc_sva
  import llrc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic mode,
  input wire logic [5:0] host_oe,
  input wire logic [5:0] dev_oe,
  input wire logic [5:0] pins,
  input wire logic driver_fail_flag,
  input wire logic no_signal_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////
  // both loop pins held high in hardware mode
  sequence s_req;
    (!mode && pins[P_RL] && pins[P_LL]) [*4];
  endsequence
  a_los_after_rst: assert property (disable iff (1'b0) rst |=> no_signal_flag)
    else $error("no_signal low after reset");
  a_dfail_rest_low: assert property (disable iff (1'b0) rst |=> !driver_fail_flag)
    else $error("driver_fail high after reset");
  a_dev_pin_mask: assert property ((dev_oe & 6'h3A) == 6'h00)
    else $error("device drives an input pin");
  // the device sees mode three cycles late, so its pins let go only then
  a_hw_no_drive: assert property (!mode && !$past(mode) && !$past(mode, 2)
    && !$past(mode, 3) |-> dev_oe == 6'h00)
    else $error("device drives a pin in hardware mode");
  a_no_contention: assert property (mode |-> (host_oe & dev_oe) == 6'h00)
    else $error("host and device drive the same pin");
  a_sdo_released: assert property ((mode && pins[P_CS]) [*8] |-> !dev_oe[P_SDO])
    else $error("serial_out driven while deselected");
  a_req_to_reset: assert property (s_req |-> ##[0:8] no_signal_flag)
    else $error("reset request left no_signal low");
  a_req_fall: assert property (!mode && !$past(mode) && $fell(pins[P_RL] && pins[P_LL])
    |-> no_signal_flag [*8])
    else $error("no_signal dropped at request release");
  // the device samples three cycles late, so the bit must outlast that
  a_sdi_hold: assert property (mode && $past(mode, 4) && !pins[P_CS] && $rose(pins[P_SCLK])
    |-> $stable(pins[P_SDI]) [*4])
    else $error("serial_in moved at serial clock rise");
  a_sclk_half: assert property (mode && $rose(pins[P_SCLK]) |-> pins[P_SCLK] [*8])
    else $error("serial clock high phase too short");
  a_sdo_edge: assert property (mode && dev_oe[P_SDO] && $past(dev_oe[P_SDO])
    && $changed(pins[P_SDO]) |-> pins[P_SCLK] != pins[P_ESEL])
    else $error("serial_out changed on the wrong edge");
endmodule : llrc_sva
`default_nettype wire

// ### tb/test_line_interface_loop_reset_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_line_interface_loop_reset_ctrl;
  import llrc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdat;
  logic [15:0] d;
  // enables: 0 tx pos, 1 tx neg, 2 rx marks, 3 monitor pulses
  logic [3:0] en_q = 4'hE;
  logic [2:0] lc_q = 3'h0;
  logic ck_q = 1'b0;
  logic clr_q = 1'b0;
  logic [3:0] seen_q = 4'h0;
  logic ta, tb, rp, rn;
  logic [2:0] span;
  logic fpl;
  logic [7:0] cv [5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hA0};
  logic [3:0] ev [5] = '{4'h6, 4'h5, 4'hE, 4'hD, 4'hA};
  int failures = 0;
  int tests_run = 0;
  llrc_if lnk ();
  //////////////////////////////////////////////////////////////////
  llrc_device #(.PWR_WAIT(200), .TRAIN(300)) u_llrc_device (
    .mclk(mclk), .rst(rst), .lnk(lnk),
    .tx_clock(ck_q), .tx_pos_data(ck_q & en_q[0]), .tx_neg_data(ck_q & en_q[1]),
    .alt_clock(ck_q), .rec_clock(ck_q), .rx_line_a(ck_q & en_q[2]), .rx_line_b(1'b0),
    .mon_line_a(ck_q & en_q[3]), .mon_line_b(1'b0),
    .tx_line_a(ta), .tx_line_b(tb), .tx_line_clk(), .rx_pos_data(rp), .rx_neg_data(rn),
    .rx_clock_out(), .cable_span_sel(span), .freq_phase_loop_busy(fpl)
  );
  llrc_host #(.HRST_HOLD(50)) u_llrc_host (
    .mclk(mclk), .rst(rst), .lnk(lnk), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat)
  );
  llrc_sva u_llrc_sva (
    .mclk(mclk), .rst(rst), .mode(lnk.mode), .host_oe(lnk.host_oe), .dev_oe(lnk.dev_oe),
    .pins(lnk.pins), .driver_fail_flag(lnk.driver_fail_flag),
    .no_signal_flag(lnk.no_signal_flag)
  );
  //////////////////////////////////////////////////////////////////
  always #5 mclk = ~mclk;
  // line clock of 80 ns, marks are return-to-zero with it
  always @(posedge mclk) begin
    lc_q <= lc_q + 3'h1;
    ck_q <= lc_q[2];
    seen_q <= clr_q ? 4'h0 : seen_q | {ta, tb, rp, rn};
  end
  //////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    ra <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [3:0] a);
    @(posedge mclk);
    ra <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdat;
  endtask : rdr
  // poll busy; a serial transfer takes some 530 cycles
  task automatic idle();
    repeat (4) @(posedge mclk);
    d = 16'hFFFF;
    for (int i = 0; i < 400 && d[0] !== 1'b0; i++) rdr(H_STAT_OFS);
    chk("busy", 16'h0, {15'h0, d[0]});
  endtask : idle
  task automatic siglow(input int n);
    for (int i = 0; i < n && lnk.no_signal_flag !== 1'b0; i++) @(posedge mclk);
    chk("no_signal", 16'h0, {15'h0, lnk.no_signal_flag});
  endtask : siglow
  task automatic obs(input logic [3:0] e);
    repeat (60) @(posedge mclk);
    clr_q <= 1'b1;
    @(posedge mclk);
    clr_q <= 1'b0;
    repeat (200) @(posedge mclk);
    chk("line activity", {12'h0, e}, {12'h0, seen_q});
  endtask : obs
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    failures++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    chk("no_signal", 16'h1, {15'h0, lnk.no_signal_flag});
    chk("driver_fail", 16'h0, {15'h0, lnk.driver_fail_flag});
    rdr(H_CTRL_OFS);
    chk("ctrl reset", 16'h0, d);
    rdr(4'hC);
    chk("unmapped", 16'h0, d);
    siglow(1000);
    $display("test power-up done");
    for (int i = 0; i < 5; i++) begin
      wrr(H_CTRL_OFS, {8'h00, cv[i]});
      obs(ev[i]);
    end
    $display("test source select done");
    wrr(H_CTRL_OFS, 16'h0000);
    en_q[3] <= 1'b0;
    repeat (112) @(posedge mclk);
    chk("driver_fail", 16'h0, {15'h0, lnk.driver_fail_flag});
    repeat (150) @(posedge mclk);
    chk("driver_fail", 16'h1, {15'h0, lnk.driver_fail_flag});
    repeat (220) @(posedge mclk);
    rdr(H_STAT_OFS);
    chk("stat driver_fail", 16'h3, {14'h0, d[3:2]});
    en_q[3] <= 1'b1;
    repeat (40) @(posedge mclk);
    chk("driver_fail", 16'h0, {15'h0, lnk.driver_fail_flag});
    $display("test driver monitor done");
    wrr(H_CMD_OFS, 16'h0200);
    repeat (80) @(posedge mclk);
    chk("no_signal", 16'h1, {15'h0, lnk.no_signal_flag});
    chk("training", 16'h1, {15'h0, fpl});
    siglow(760);
    chk("training", 16'h0, {15'h0, fpl});
    $display("test hardware reset done");
    wrr(H_CTRL_OFS, 16'h0001);
    wrr(H_CMD_OFS, 16'h001F);
    idle();
    chk("span", 16'h7, {13'h0, span});
    en_q[3] <= 1'b0;
    repeat (300) @(posedge mclk);
    wrr(H_CMD_OFS, 16'h0100);
    idle();
    chk("read byte", 16'h001E, {8'h0, d[15:8]});
    en_q[3] <= 1'b1;
    wrr(H_CTRL_OFS, 16'h0003);
    repeat (50) @(posedge mclk);
    wrr(H_CMD_OFS, 16'h0100);
    idle();
    chk("read byte", 16'h001C, {8'h0, d[15:8]});
    wrr(H_CMD_OFS, 16'h0060);
    idle();
    repeat (20) @(posedge mclk);
    chk("no_signal", 16'h1, {15'h0, lnk.no_signal_flag});
    siglow(760);
    chk("span", 16'h0, {13'h0, span});
    wrr(H_CMD_OFS, 16'h0100);
    idle();
    chk("read byte", 16'h0000, {8'h0, d[15:8]});
    $display("test host mode done");
    conclude();
  end
endmodule : test_line_interface_loop_reset_ctrl
`default_nettype wire
